/* src/sfsm_defines.svh */
`ifndef SFSM_DEFINES_SVH
`define SFSM_DEFINES_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define SFSM_CLK_KHZ        20000
`define SFSM_STALL_MS       20
`define SFSM_STALL_ALT_MS   50
`define SFSM_START_SEC      15
`define SFSM_START_ALT_SEC  60
`define SFSM_RESTORE_MS     1000
`define SFSM_BLINK_MS       250
`define SFSM_STALL_CYC      (`SFSM_STALL_MS * `SFSM_CLK_KHZ)
`define SFSM_START_CYC      (`SFSM_START_SEC * 1000 * `SFSM_CLK_KHZ)
`define SFSM_RESTORE_CYC    (`SFSM_RESTORE_MS * `SFSM_CLK_KHZ)
`define SFSM_BLINK_CYC      (`SFSM_BLINK_MS * `SFSM_CLK_KHZ)

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define SFSM_ADDR_W         8
`define SFSM_OFS_THRESH     8'h04
`define SFSM_OFS_STATUS     8'h08
`define SFSM_OFS_IRQ_STAT   8'h0c
`define SFSM_OFS_IRQ_EN     8'h10
`define SFSM_OFS_IRQ_CLR    8'h14

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define SFSM_SMP_W          12
`define SFSM_THRESH_RST     12'h040
`define SFSM_EV_N           4
`define SFSM_EV_FAULT       0
`define SFSM_EV_RECOVER     1
`define SFSM_EV_READY       2
`define SFSM_EV_ILK_OPEN    3
`define SFSM_ST_STATE_LSB   0
`define SFSM_ST_MODE        4
`define SFSM_ST_ILK_OK      5
`define SFSM_ST_LASER       6
`define SFSM_ST_FAULT       7

`endif

/* src/sfsm_pkg.sv */
package sfsm_pkg;
    typedef enum logic [3:0] {
        SFSM_START = 4'h1,
        SFSM_RUN   = 4'h2,
        SFSM_FAULT = 4'h4,
        SFSM_HOLD  = 4'h8
    } sfsm_state_type;

    typedef struct packed {
        sfsm_state_type state;
        logic [31:0]    cnt;
        logic [31:0]    blink_cnt;
        logic           blink;
        logic           mode_input;
        logic           mode_valid;
        logic [11:0]    thresh;
        logic [3:0]     irq_stat;
        logic [3:0]     irq_en;
        logic           ilk_ok_d;
        logic [7:0]     ha_addr;
        logic           ha_wr;
        logic           ha_act;
        logic [31:0]    hrdata;
    } sfsm_main_type;
endpackage : sfsm_pkg

/* src/sfsm_motion_det.sv */
`timescale 1ns/1ps
`include "sfsm_defines.svh"

module sfsm_motion_det #(
    parameter int W     = `SFSM_SMP_W,
    parameter int LIMIT = `SFSM_STALL_CYC
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // sample and threshold
    input  wire logic [W-1:0] sample,
    input  wire logic [W-1:0] thresh,
    // result
    output logic              still
);
    import sfsm_pkg::*;
    localparam int CW = $clog2(LIMIT + 1);

    typedef struct packed {
        logic [W-1:0]  ref_smp;
        logic [CW-1:0] cnt;
        logic          still;
    } sfsm_det_type;

    sfsm_det_type s_r;
    sfsm_det_type s_nxt;
    logic signed [W:0] diff;
    logic [W:0]        mag;
    logic              moved;

    always_comb begin
        s_nxt = s_r;
        diff  = $signed({sample[W-1], sample}) - $signed({s_r.ref_smp[W-1], s_r.ref_smp});
        mag   = diff[W] ? (W+1)'(0) - diff : diff;
        // RQ8: excursion against threshold
        moved = mag >= {1'b0, thresh};
        if (moved) begin
            s_nxt.ref_smp = sample;
            s_nxt.cnt     = '0;
            s_nxt.still   = 1'b0;
        end else if (s_r.cnt == CW'(LIMIT - 1)) begin
            // RQ1: static past stall limit
            s_nxt.still = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign still = s_r.still;

    AST_MOVE_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
        moved |=> (s_r.cnt == '0) && !still)
        else $error("movement above threshold did not restart stall timer");
endmodule : sfsm_motion_det

/* src/sfsm_monitor.sv */
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "sfsm_defines.svh"

// What this block does
// RQ1: any scanner static past stall limit is a fault, all lasers cut.
// RQ2: monitoring starts only after a build-time start-up period.
// RQ3: low feedback amplitude or missing feedback are faults.
// RQ4: scanner mode watches feedback; input mode also watches command movement.
// RQ5: mode selector is sampled only at start-up.
// RQ6: scanner mode: no feedback movement always cuts output.
// RQ7: input mode: cut only when feedback still while command moves.
// RQ8: amplitude compared to adjustable threshold.
// RQ9: restore at once in scanner mode, after 1000 ms in input mode.
// RQ10: monitor switch off forces outputs enabled, faults ignored.
// RQ11: emission indicator lit exactly when output is possible.
// RQ12: emission needs all interlocks closed, key on, covers shut.
// RQ13: start-up period blocks emission and blinks status indicator.
// RQ14: one enable combines fault, interlock and start-up gating.
module sfsm_monitor #(
    parameter int N_ILK       = 2,
    parameter int N_COVER     = 2,
    parameter int STALL_CYC   = `SFSM_STALL_CYC,
    parameter int START_CYC   = `SFSM_START_CYC,
    parameter int RESTORE_CYC = `SFSM_RESTORE_CYC,
    parameter int BLINK_CYC   = `SFSM_BLINK_CYC
) (
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // ahb-lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    // axis samples
    input  wire logic [`SFSM_SMP_W-1:0] cmd_x,
    input  wire logic [`SFSM_SMP_W-1:0] cmd_y,
    input  wire logic [`SFSM_SMP_W-1:0] fb_x,
    input  wire logic [`SFSM_SMP_W-1:0] fb_y,
    input  wire logic [1:0]             fb_present,
    // switches and loops
    input  wire logic                   mode_sel_input,
    input  wire logic                   monitor_en,
    input  wire logic [N_ILK-1:0]       interlock_closed,
    input  wire logic                   key_on,
    input  wire logic [N_COVER-1:0]     cover_closed,
    // outputs
    output logic                        laser_en,
    output logic                        emission_led,
    output logic                        status_led,
    output logic                        irq
);
    import sfsm_pkg::*;

    localparam int NAX = 4;

    sfsm_main_type         s_r;
    sfsm_main_type         s_nxt;
    logic [`SFSM_SMP_W-1:0] smp [NAX];
    logic [NAX-1:0]        still;
    logic                  fb_lost;
    logic                  fault;
    logic                  ilk_ok;
    logic                  gate;
    logic [3:0]            ev;
    logic                  wr_ph;
    logic [31:0]           rd_val;

    // ---------------------------------------------------------------
    // movement detectors: 0,1 feedback, 2,3 command
    // ---------------------------------------------------------------
    assign smp[0] = fb_x;
    assign smp[1] = fb_y;
    assign smp[2] = cmd_x;
    assign smp[3] = cmd_y;

    generate
        for (genvar i = 0; i < NAX; i++) begin : g_det
            sfsm_motion_det #(
                .W     (`SFSM_SMP_W),
                .LIMIT (STALL_CYC)
            ) u_det (
                .hclk    (hclk),
                .hresetn (hresetn),
                .sample  (smp[i]),
                .thresh  (s_r.thresh),
                .still   (still[i])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // fault and gating
    // ---------------------------------------------------------------
    // RQ3: missing feedback
    assign fb_lost = ~&fb_present;
    // RQ12: every loop must be closed
    assign ilk_ok  = (&interlock_closed) & key_on & (&cover_closed);

    always_comb begin
        // RQ4: mode chooses which signals count
        if (s_r.mode_input) begin
            // RQ7: per axis, still feedback with moving command
            fault = fb_lost | (still[0] & ~still[2]) | (still[1] & ~still[3]);
        end else begin
            // RQ6: any still feedback cuts output
            fault = fb_lost | still[0] | still[1];
        end
    end

    // RQ14: single enable, any condition forbids
    // RQ10: switch off overrides fault states
    assign gate         = (s_r.state != SFSM_START) & (~monitor_en | (s_r.state == SFSM_RUN));
    assign laser_en     = gate & ilk_ok;
    // RQ11: indicator follows possibility of emission
    assign emission_led = laser_en;
    assign status_led   = s_r.blink;
    assign irq          = |(s_r.irq_stat & s_r.irq_en);
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = s_r.hrdata;
    assign wr_ph        = s_r.ha_act & s_r.ha_wr & hready;

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        case (haddr[`SFSM_ADDR_W-1:0])
            `SFSM_OFS_THRESH: begin
                rd_val[`SFSM_SMP_W-1:0] = s_r.thresh;
            end
            `SFSM_OFS_STATUS: begin
                rd_val[`SFSM_ST_STATE_LSB +: 4] = s_r.state;
                rd_val[`SFSM_ST_MODE]            = s_r.mode_input;
                rd_val[`SFSM_ST_ILK_OK]          = ilk_ok;
                rd_val[`SFSM_ST_LASER]           = laser_en;
                rd_val[`SFSM_ST_FAULT]           = fault;
            end
            `SFSM_OFS_IRQ_STAT: begin
                rd_val[`SFSM_EV_N-1:0] = s_r.irq_stat;
            end
            `SFSM_OFS_IRQ_EN: begin
                rd_val[`SFSM_EV_N-1:0] = s_r.irq_en;
            end
            default: begin
                rd_val = '0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        ev    = '0;

        // RQ5: selector caught once after reset release
        if (!s_r.mode_valid) begin
            s_nxt.mode_valid = 1'b1;
            s_nxt.mode_input = mode_sel_input;
        end

        s_nxt.ilk_ok_d = ilk_ok;
        if (s_r.ilk_ok_d && !ilk_ok) begin
            ev[`SFSM_EV_ILK_OPEN] = 1'b1;
        end

        case (s_r.state)
            SFSM_START: begin
                // RQ13: blink while emission blocked
                if (s_r.blink_cnt == 32'(BLINK_CYC - 1)) begin
                    s_nxt.blink_cnt = '0;
                    s_nxt.blink     = ~s_r.blink;
                end else begin
                    s_nxt.blink_cnt = s_r.blink_cnt + 32'h1;
                end
                // RQ2: monitoring begins after start-up period
                if (s_r.cnt == 32'(START_CYC - 1)) begin
                    s_nxt.state = SFSM_RUN;
                    s_nxt.cnt   = '0;
                    s_nxt.blink = 1'b0;
                    ev[`SFSM_EV_READY] = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt + 32'h1;
                end
            end
            SFSM_RUN: begin
                // RQ1: fault cuts every laser at once
                if (fault && monitor_en) begin
                    s_nxt.state = SFSM_FAULT;
                    ev[`SFSM_EV_FAULT] = 1'b1;
                end
            end
            SFSM_FAULT: begin
                // RQ9: scanner mode immediate, input mode delayed
                if (!fault || !monitor_en) begin
                    s_nxt.cnt = '0;
                    if (s_r.mode_input && monitor_en) begin
                        s_nxt.state = SFSM_HOLD;
                    end else begin
                        s_nxt.state = SFSM_RUN;
                        ev[`SFSM_EV_RECOVER] = 1'b1;
                    end
                end
            end
            SFSM_HOLD: begin
                if (fault && monitor_en) begin
                    s_nxt.state = SFSM_FAULT;
                end else if (s_r.cnt == 32'(RESTORE_CYC - 1) || !monitor_en) begin
                    s_nxt.state = SFSM_RUN;
                    ev[`SFSM_EV_RECOVER] = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt + 32'h1;
                end
            end
            default: begin
                s_nxt.state = SFSM_START;
                s_nxt.cnt   = '0;
            end
        endcase

        // bus data phase; clear first so a same-cycle event still sets
        if (wr_ph) begin
            case (s_r.ha_addr)
                `SFSM_OFS_THRESH: begin
                    s_nxt.thresh = hwdata[`SFSM_SMP_W-1:0];
                end
                `SFSM_OFS_IRQ_EN: begin
                    s_nxt.irq_en = hwdata[`SFSM_EV_N-1:0];
                end
                `SFSM_OFS_IRQ_CLR: begin
                    s_nxt.irq_stat = s_r.irq_stat & ~hwdata[`SFSM_EV_N-1:0];
                end
                default: begin
                    s_nxt.irq_en = s_nxt.irq_en;
                end
            endcase
        end
        s_nxt.irq_stat = s_nxt.irq_stat | ev;

        // address phase
        s_nxt.ha_act = 1'b0;
        if (hsel && htrans[1] && hready) begin
            s_nxt.ha_act  = 1'b1;
            s_nxt.ha_wr   = hwrite;
            s_nxt.ha_addr = haddr[`SFSM_ADDR_W-1:0];
            if (!hwrite) begin
                s_nxt.hrdata = rd_val;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r        <= '0;
            s_r.state  <= SFSM_START;
            s_r.thresh <= `SFSM_THRESH_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_START_BLOCKS: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
        (s_r.state == SFSM_START) |-> !laser_en && !emission_led)
        else $error("emission possible during start-up");

    AST_START_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
        (s_r.state == SFSM_START) && (s_r.cnt != 32'(START_CYC - 1)) |=> (s_r.state == SFSM_START))
        else $error("start-up period ended early");

    AST_ILK_CUTS: assert property (@(posedge hclk) disable iff (!hresetn) // RQ12
        !ilk_ok |-> !laser_en && !emission_led)
        else $error("emission with open interlock");

    AST_BYPASS: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
        !monitor_en && ilk_ok && (s_r.state != SFSM_START) |-> laser_en)
        else $error("bypassed monitor still cut output");

    AST_STALL_CUT: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
        monitor_en && (s_r.state == SFSM_RUN) && fault |=> !laser_en)
        else $error("fault did not cut emission next cycle");

    AST_FB_LOST: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        fb_lost |-> fault)
        else $error("missing feedback not a fault");

    AST_SCAN_STILL: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
        !s_r.mode_input && (still[0] || still[1]) |-> fault)
        else $error("still feedback tolerated in scanner mode");

    AST_INPUT_STATIC_OK: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        s_r.mode_input && !fb_lost && (&still[3:2]) |-> !fault)
        else $error("static command flagged in input mode");

    AST_MODE_FROZEN: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
        s_r.mode_valid |=> $stable(s_r.mode_input))
        else $error("mode changed while running");

    AST_SCAN_RESTORE: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        (s_r.state == SFSM_FAULT) && !s_r.mode_input && !fault |=> (s_r.state == SFSM_RUN))
        else $error("scanner mode restore not immediate");

    AST_INPUT_DELAY: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        (s_r.state == SFSM_FAULT) && s_r.mode_input && monitor_en && !fault
        |=> !laser_en ##1 !laser_en)
        else $error("input mode restored without delay");

    AST_MODE_SELECT: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
        !fb_lost && s_r.mode_input && still[0] && still[2] && !still[1] |-> !fault)
        else $error("input mode ignored command movement");

    AST_ONE_ENABLE: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
        monitor_en && (s_r.state inside {SFSM_FAULT, SFSM_HOLD}) |-> !laser_en)
        else $error("enable high while fault gate closed");

    AST_LED_TRACK: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
        $rose(laser_en) |-> emission_led && $rose(emission_led))
        else $error("indicator out of step with emission");

    AST_THRESH_WR: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
        wr_ph && (s_r.ha_addr == `SFSM_OFS_THRESH) |=> (s_r.thresh == $past(hwdata[`SFSM_SMP_W-1:0])))
        else $error("threshold write lost");

    AST_IRQ_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
        ev[`SFSM_EV_FAULT] |=> s_r.irq_stat[`SFSM_EV_FAULT])
        else $error("fault event lost to a same-cycle clear");

    AST_HOLD_TIME: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        (s_r.state == SFSM_HOLD) && monitor_en && !fault && (s_r.cnt != 32'(RESTORE_CYC - 1))
        |=> (s_r.state == SFSM_HOLD))
        else $error("input mode restore delay cut short");

    AST_BLINK_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
        (s_r.state == SFSM_START) && (s_r.blink_cnt == 32'(BLINK_CYC - 1))
        && (s_r.cnt != 32'(START_CYC - 1)) |=> (status_led != $past(status_led)))
        else $error("status indicator did not toggle in start-up");
endmodule : sfsm_monitor

/* verification/sfsm_scan_model.sv */
`timescale 1ns/1ps
`include "sfsm_defines.svh"

module sfsm_scan_model (
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // scenario knobs
    input  wire logic [1:0]             cmd_move,
    input  wire logic [1:0]             fb_move,
    input  wire logic [1:0]             fb_on,
    input  wire logic [`SFSM_SMP_W-1:0] step,
    // axis samples
    output logic [`SFSM_SMP_W-1:0]      cmd_x,
    output logic [`SFSM_SMP_W-1:0]      cmd_y,
    output logic [`SFSM_SMP_W-1:0]      fb_x,
    output logic [`SFSM_SMP_W-1:0]      fb_y,
    output logic [1:0]                  fb_present
);
    logic ph_r;

    // ---------------------------------------
    // controller swing and scanner echo
    // ---------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r       <= 1'b0;
            cmd_x      <= '0;
            cmd_y      <= '0;
            fb_x       <= '0;
            fb_y       <= '0;
            fb_present <= 2'b11;
        end else begin
            ph_r       <= ~ph_r;
            fb_present <= fb_on;
            if (cmd_move[0]) cmd_x <= ph_r ? step : '0;
            if (cmd_move[1]) cmd_y <= ph_r ? step : '0;
            // lost feedback
            // a cut cable floats: toggle instead of holding the old value
            if (!fb_on[0]) fb_x <= ~fb_x;
            else if (fb_move[0]) fb_x <= ph_r ? step : '0;
            if (!fb_on[1]) fb_y <= ~fb_y;
            else if (fb_move[1]) fb_y <= ph_r ? step : '0;
        end
    end
endmodule : sfsm_scan_model

/* verification/sfsm_monitor_tb_top.sv */
`timescale 1ns/1ps
`include "sfsm_defines.svh"

module sfsm_monitor_tb_top;
    import sfsm_pkg::*;
    // short counts keep the run small
    localparam int STALL = 20;
    localparam int START = 50;
    localparam int RESTORE = 30;
    localparam int BLINK = 4;

    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, seed, rd;
    logic [1:0]  htrans, cmd_move, fb_move, fb_on, fb_present, interlock_closed, cover_closed;
    logic [2:0]  hsize;
    logic [11:0] cmd_x, cmd_y, fb_x, fb_y, step;
    logic        mode_sel_input, monitor_en, key_on, laser_en, emission_led, status_led, irq;
    int          errors, n_tests, blinks;

    assign hready = hreadyout;

    sfsm_monitor #(.STALL_CYC(STALL), .START_CYC(START), .RESTORE_CYC(RESTORE), .BLINK_CYC(BLINK)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cmd_x(cmd_x), .cmd_y(cmd_y), .fb_x(fb_x), .fb_y(fb_y), .fb_present(fb_present),
        .mode_sel_input(mode_sel_input), .monitor_en(monitor_en), .interlock_closed(interlock_closed),
        .key_on(key_on), .cover_closed(cover_closed), .laser_en(laser_en), .emission_led(emission_led),
        .status_led(status_led), .irq(irq));

    sfsm_scan_model u_scan (
        .hclk(hclk), .hresetn(hresetn), .cmd_move(cmd_move), .fb_move(fb_move), .fb_on(fb_on),
        .step(step), .cmd_x(cmd_x), .cmd_y(cmd_y), .fb_x(fb_x), .fb_y(fb_y), .fb_present(fb_present));

    // ---------------------------------------
    // helpers
    // ---------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // one single ahb-lite transfer, waits on hready with no bound of its own
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
        int k;
        k = 0;
        @(posedge hclk);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do begin @(posedge hclk); k++; end while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge hclk); k++; end while (hready !== 1'b1);
        d = hrdata;
        // zero wait states: address edge plus data edge
        check("hready answered", 32'h2, 32'(k));
        check("hresp okay", 32'h0, {31'h0, hresp});
        #1;
    endtask : ahb

    task automatic wreg(input logic [7:0] a, input logic [31:0] wd);
        ahb(1'b1, a, wd, rd);
    endtask : wreg

    task automatic rreg(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0, rd);
        check(what, exp, rd);
    endtask : rreg

    task automatic wait_laser(input logic exp, input int lo, input int hi);
        int k;
        k = 0;
        do begin @(posedge hclk); #1; k++; end while (laser_en !== exp && k <= hi);
        check("laser_en timing", 32'h1, 32'(k >= lo && k <= hi));
        check("emission_led", {31'h0, laser_en}, {31'h0, emission_led});
    endtask : wait_laser

    task automatic hold_laser(input logic exp, input int n);
        int bad;
        bad = 0;
        repeat (n) begin @(posedge hclk); #1; if (laser_en !== exp) bad++; end
        check("laser_en held", 32'h0, 32'(bad));
    endtask : hold_laser

    task automatic boot(input logic mode);
        hresetn        <= 1'b0;
        mode_sel_input <= mode;
        repeat (5) @(posedge hclk);
        blinks = 0;
        hresetn <= 1'b1;
        wait_laser(1'b1, START - 2, START + 5);
        check("blink count", 32'h1, 32'(blinks >= START / (2 * BLINK) - 1 && blinks <= START / (2 * BLINK) + 1));
        check("status_led idle", 32'h0, {31'h0, status_led});
        mode_sel_input <= ~mode;
    endtask : boot

    always @(posedge status_led) blinks++;

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        $display("Error watchdog expected finish seen hang");
        end_sim();
    end

    // ---------------------------------------
    // scenarios
    // ---------------------------------------
    initial begin
        hresetn = 1'b0; hsel = 1'b1; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = '0;
        cmd_move = 2'b11; fb_move = 2'b11; fb_on = 2'b11; step = 12'h080; mode_sel_input = 1'b0;
        monitor_en = 1'b1; interlock_closed = 2'b11; key_on = 1'b1; cover_closed = 2'b11;
        errors = 0; n_tests = 0; blinks = 0; seed = 32'h447b;
        boot(1'b0);
        rreg("thresh reset", `SFSM_OFS_THRESH, 32'h40);
        rreg("status scanner", `SFSM_OFS_STATUS, {24'h0, 4'h6, SFSM_RUN});
        rreg("unmapped", 8'h3c, 32'h0);
        rreg("irq_en reset", `SFSM_OFS_IRQ_EN, 32'h0);
        ahb(1'b0, `SFSM_OFS_IRQ_STAT, 32'h0, rd);
        check("ready event", 32'h1, {31'h0, rd[`SFSM_EV_READY]});
        wreg(`SFSM_OFS_IRQ_EN, 32'h4);
        check("irq raised", 32'h1, {31'h0, irq});
        wreg(`SFSM_OFS_IRQ_EN, 32'h0);
        check("irq masked", 32'h0, {31'h0, irq});
        wreg(`SFSM_OFS_IRQ_CLR, 32'hf);
        wreg(`SFSM_OFS_IRQ_EN, 32'h1);
        rreg("irq cleared", `SFSM_OFS_IRQ_STAT, 32'h0);
        seed = xs(seed);
        wreg(`SFSM_OFS_THRESH, seed);
        rreg("thresh rw", `SFSM_OFS_THRESH, {20'h0, seed[11:0]});
        wreg(`SFSM_OFS_THRESH, 32'h40);
        $display("test boot and registers done");
        for (int ax = 0; ax < 2; ax++) begin
            fb_move  <= ~(2'b01 << ax);
            cmd_move <= ~(2'b01 << ax);
            wait_laser(1'b0, STALL - 2, STALL + 5);
            check("fault irq", 32'h1, {31'h0, irq});
            fb_move  <= 2'b11;
            cmd_move <= 2'b11;
            wait_laser(1'b1, 0, 3);
            fb_on <= ~(2'b01 << ax);
            wait_laser(1'b0, 0, 4);
            fb_on <= 2'b11;
            wait_laser(1'b1, 0, 4);
        end
        seed = xs(seed);
        step <= 12'h040 + {6'h0, seed[5:0]};
        // step is not yet updated here: threshold one above the new swing
        wreg(`SFSM_OFS_THRESH, {20'h0, 12'h041 + {6'h0, seed[5:0]}});
        wait_laser(1'b0, STALL - 4, STALL + 5);
        wreg(`SFSM_OFS_THRESH, {20'h0, step});
        wait_laser(1'b1, 0, 5);
        $display("test scanner watch done");
        monitor_en <= 1'b0;
        fb_on      <= 2'b00;
        hold_laser(1'b1, STALL + 10);
        monitor_en <= 1'b1;
        fb_on      <= 2'b11;
        wreg(`SFSM_OFS_IRQ_CLR, 32'hf);
        wreg(`SFSM_OFS_IRQ_EN, 32'h8);
        for (int i = 0; i < 5; i++) begin
            {cover_closed, key_on, interlock_closed} <= ~(5'b00001 << i);
            monitor_en <= 1'(i);
            wait_laser(1'b0, 0, 2);
            {cover_closed, key_on, interlock_closed} <= 5'b11111;
            wait_laser(1'b1, 0, 2);
        end
        monitor_en <= 1'b1;
        check("interlock irq", 32'h1, {31'h0, irq});
        $display("test bypass and interlocks done");
        boot(1'b1);
        rreg("status input", `SFSM_OFS_STATUS, {24'h0, 4'h7, SFSM_RUN});
        cmd_move <= 2'b01;
        fb_move  <= 2'b01;
        hold_laser(1'b1, STALL + 10);
        fb_move <= 2'b00;
        wait_laser(1'b0, STALL - 2, STALL + 5);
        fb_move <= 2'b11;
        cmd_move <= 2'b11;
        wait_laser(1'b1, RESTORE - 2, RESTORE + 6);
        $display("test input watch done");
        end_sim();
    end
endmodule : sfsm_monitor_tb_top
